// *** rtl/step_dir_servo_io.sv ***
// Notes on behaviour
// - single-pulse mode: each selected step edge moves commanded position one step.
// - single-pulse mode: direction is a level, high counts up, low counts down.
// - double-pulse mode: step pulses are clockwise steps.
// - double-pulse mode: direction pulses are counter-clockwise steps.
// - driver is off while the enable input is low.
// - in-position output opens when actual position equals commanded position.
// - alarm output changes state while any protection is active.
// - on alarm, in-position opens and alarm output closes (opens when normally closed is selected).
// - over-voltage, over-current and position error each count as protection events.
// - green power indicator stays lit while running.
// - red indicator flashes, or for over-current lights steadily, while a fault is latched, off once cleared.
// - red pattern: 1 s flash lost step, steady over-current, 2 s over-voltage.
// - control bit selects rising (0, default) or falling (1) step edge.
// - control bit selects alarm output normally open (0) or closed (1).
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module step_dir_servo_io #(
   parameter int unsigned POS_W          = 32,
   parameter int unsigned LOST_HALF_CYC  = servo_io_pkg::LOST_STEP_HALF_CYCLES,
   parameter int unsigned VOLT_HALF_CYC  = servo_io_pkg::OVER_VOLT_HALF_CYCLES
) (
   input  wire logic                              core_clk,
   input  wire logic                              arst_n,
   input  wire logic                              ce,
   input  wire logic                              step_in,
   input  wire logic                              dir_in,
   input  wire logic                              drive_enable_in,
   input  wire logic                              over_voltage_in,
   input  wire logic                              over_current_in,
   input  wire logic [POS_W-1:0]                  act_pos,
   input  wire logic [servo_io_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                              avs_read,
   input  wire logic                              avs_write,
   input  wire logic [servo_io_pkg::DATA_W-1:0]   avs_writedata,
   input  wire logic [servo_io_pkg::BE_W-1:0]     avs_byteenable,
   output logic      [servo_io_pkg::DATA_W-1:0]   avs_readdata,
   output logic                                   avs_waitrequest,
   output logic                                   irq,
   output logic                                   in_position_out,
   output logic                                   fault_alert_out,
   output logic                                   driver_on_out,
   output logic                                   power_led_out,
   output logic                                   fault_led_out
);
   localparam logic [POS_W-1:0] POS_ONE = {{(POS_W-1){1'b0}}, 1'b1};

   logic                              rst_meta;
   logic                              rst_n;
   logic [servo_io_pkg::SY_W-1:0]     sync1;
   logic [servo_io_pkg::SY_W-1:0]     sync2;
   logic [servo_io_pkg::SY_W-1:0]     prev;
   logic [servo_io_pkg::CTRL_W-1:0]   ctrl;
   logic [POS_W-1:0]                  cmd_pos;
   logic [POS_W-1:0]                  next_cmd_pos;
   logic [POS_W-1:0]                  max_err;
   logic [POS_W-1:0]                  pos_diff;
   logic [POS_W-1:0]                  pos_mag;
   logic [servo_io_pkg::FLT_W-1:0]    fault;
   logic [servo_io_pkg::FLT_W-1:0]    fault_src;
   logic [servo_io_pkg::EV_W-1:0]     irq_status;
   logic [servo_io_pkg::EV_W-1:0]     irq_mask;
   logic [servo_io_pkg::EV_W-1:0]     events;
   logic [servo_io_pkg::DATA_W-1:0]   rd_mux;
   logic [31:0]                       blink_half;
   servo_io_pkg::bus_state_t          bus_state;
   logic                              wr_fire;
   logic                              step_hit;
   logic                              dir_hit;
   logic                              drv_en;
   logic                              in_pos;
   logic                              alarm;
   logic                              pos_err;
   logic                              clear_req;
   logic                              blink_run;
   logic                              blink_lit;

   // edge of a synchronised input; falling selects the high-to-low edge
   function automatic logic edge_hit(input logic cur, input logic old, input logic fall);
      edge_hit = fall ? (old & ~cur) : (cur & ~old);
   endfunction

   // byte-enable merge of a bus write into a register image
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  be);
      logic [31:0] mask;
      mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      be_merge = (old & ~mask) | (data & mask);
   endfunction

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // isolated pins: two stages, then a third copy for edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else if (ce) begin
         sync1 <= {over_current_in, over_voltage_in, drive_enable_in, dir_in, step_in};
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   // edges are taken only from the second stage and its delayed copy
   assign step_hit = edge_hit(sync2[servo_io_pkg::SY_STEP], prev[servo_io_pkg::SY_STEP],
                              ctrl[servo_io_pkg::CTRL_FALLING]);
   assign dir_hit  = edge_hit(sync2[servo_io_pkg::SY_DIR], prev[servo_io_pkg::SY_DIR],
                              ctrl[servo_io_pkg::CTRL_FALLING]);
   assign drv_en   = sync2[servo_io_pkg::SY_EN];

   // step counting; pulses while disabled are dropped, not queued
   always_comb begin
      next_cmd_pos = cmd_pos;
      if (drv_en) begin
         if (ctrl[servo_io_pkg::CTRL_DOUBLE]) begin
            // simultaneous cw and ccw pulses cancel
            if (step_hit && !dir_hit) begin
               next_cmd_pos = cmd_pos + POS_ONE;
            end else if (dir_hit && !step_hit) begin
               next_cmd_pos = cmd_pos - POS_ONE;
            end
         end else if (step_hit) begin
            next_cmd_pos = sync2[servo_io_pkg::SY_DIR] ? cmd_pos + POS_ONE
                                                        : cmd_pos - POS_ONE;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_pos <= '0;
      end else if (ce) begin
         cmd_pos <= next_cmd_pos;
      end
   end

   // position error magnitude against the software limit
   assign pos_diff = cmd_pos - act_pos;
   assign pos_mag  = pos_diff[POS_W-1] ? (~pos_diff + POS_ONE) : pos_diff;
   assign pos_err  = pos_mag > max_err;
   assign in_pos   = (cmd_pos == act_pos);

   // latched faults; a source still present at clear time re-latches
   assign fault_src[servo_io_pkg::FLT_OV] = sync2[servo_io_pkg::SY_OV];
   assign fault_src[servo_io_pkg::FLT_OC] = sync2[servo_io_pkg::SY_OC];
   assign fault_src[servo_io_pkg::FLT_PE] = pos_err;
   assign clear_req = wr_fire && (avs_address == servo_io_pkg::REG_CTRL) &&
                      avs_byteenable[0] && avs_writedata[servo_io_pkg::CTRL_CLEAR];
   assign alarm     = |fault;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault <= '0;
      end else if (ce) begin
         fault <= (clear_req ? '0 : fault) | fault_src;
      end
   end

   // status outputs: 1 means the open-collector stage conducts
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_position_out <= 1'b1;
         fault_alert_out <= 1'b0;
         driver_on_out   <= 1'b0;
         power_led_out   <= 1'b0;
      end else if (ce) begin
         in_position_out <= !(in_pos || alarm);
         fault_alert_out <= alarm ^ ctrl[servo_io_pkg::CTRL_ALARM_NC];
         driver_on_out   <= drv_en && !alarm;
         power_led_out   <= 1'b1;
      end
   end

   // fault indicator: over-current steady, then lost step, then over-voltage
   assign blink_run  = !fault[servo_io_pkg::FLT_OC] &&
                       (fault[servo_io_pkg::FLT_PE] || fault[servo_io_pkg::FLT_OV]);
   assign blink_half = fault[servo_io_pkg::FLT_PE] ? LOST_HALF_CYC : VOLT_HALF_CYC;

   blink_timer u_blink (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .ce          (ce),
      .run         (blink_run),
      .half_cycles (blink_half),
      .lit         (blink_lit)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_led_out <= 1'b0;
      end else if (ce) begin
         if (fault[servo_io_pkg::FLT_OC]) begin
            fault_led_out <= 1'b1;
         end else begin
            fault_led_out <= blink_run && blink_lit;
         end
      end
   end

   // bus handshake: one wait cycle, then waitrequest low for exactly one cycle
   assign wr_fire = (bus_state == servo_io_pkg::BUS_ACK) && avs_write;

   always_comb begin
      rd_mux = '0;
      case (avs_address)
         servo_io_pkg::REG_CTRL:       rd_mux = 32'(ctrl);
         servo_io_pkg::REG_CMD_POS:    rd_mux = 32'(cmd_pos);
         servo_io_pkg::REG_FAULT:      rd_mux = 32'({driver_on_out, drv_en, in_pos, fault});
         servo_io_pkg::REG_IRQ_STATUS: rd_mux = 32'(irq_status);
         servo_io_pkg::REG_IRQ_MASK:   rd_mux = 32'(irq_mask);
         servo_io_pkg::REG_MAX_ERR:    rd_mux = 32'(max_err);
         default:                      rd_mux = '0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state       <= servo_io_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
      end else if (ce) begin
         case (bus_state)
            servo_io_pkg::BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state       <= servo_io_pkg::BUS_ACK;
                  avs_waitrequest <= 1'b0;
                  avs_readdata    <= avs_read ? rd_mux : '0;
               end
            end
            servo_io_pkg::BUS_ACK: begin
               bus_state       <= servo_io_pkg::BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state       <= servo_io_pkg::BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // configuration registers; the clear bit is a strobe and is not stored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl    <= servo_io_pkg::CTRL_RESET;
         max_err <= POS_W'(servo_io_pkg::MAX_ERR_RESET);
      end else if (ce && wr_fire) begin
         if (avs_address == servo_io_pkg::REG_CTRL) begin
            ctrl <= servo_io_pkg::CTRL_W'(be_merge(32'(ctrl), avs_writedata,
                                                   avs_byteenable));
         end
         if (avs_address == servo_io_pkg::REG_MAX_ERR) begin
            max_err <= POS_W'(be_merge(32'(max_err), avs_writedata, avs_byteenable));
         end
      end
   end

   // sticky events, write one to clear; a new event wins over the clear
   assign events = {in_pos, fault_src};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
         irq_mask   <= '0;
         irq        <= 1'b0;
      end else if (ce) begin
         if (wr_fire && avs_address == servo_io_pkg::REG_IRQ_STATUS && avs_byteenable[0]) begin
            irq_status <= (irq_status & ~avs_writedata[servo_io_pkg::EV_W-1:0]) | events;
         end else begin
            irq_status <= irq_status | events;
         end
         if (wr_fire && avs_address == servo_io_pkg::REG_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[servo_io_pkg::EV_W-1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // checks on the design's own outputs
   AST_SINGLE_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && drv_en && !ctrl[servo_io_pkg::CTRL_DOUBLE] && step_hit && sync2[servo_io_pkg::SY_DIR]
      |=> cmd_pos == $past(cmd_pos) + POS_ONE)
      else $error("single-pulse step did not count up");
   AST_SINGLE_DOWN: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && drv_en && !ctrl[servo_io_pkg::CTRL_DOUBLE] && step_hit && !sync2[servo_io_pkg::SY_DIR]
      |=> cmd_pos == $past(cmd_pos) - POS_ONE)
      else $error("low direction did not count down");
   AST_DOUBLE_CW: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && drv_en && ctrl[servo_io_pkg::CTRL_DOUBLE] && step_hit && !dir_hit
      |=> cmd_pos == $past(cmd_pos) + POS_ONE)
      else $error("cw pulse not counted");
   AST_DOUBLE_CCW: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && drv_en && ctrl[servo_io_pkg::CTRL_DOUBLE] && dir_hit && !step_hit
      |=> cmd_pos == $past(cmd_pos) - POS_ONE)
      else $error("ccw pulse not counted");
   AST_DISABLED: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && !drv_en |=> !driver_on_out && $stable(cmd_pos))
      else $error("driver active or counting while disabled");
   AST_IN_POS_OPEN: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && in_pos |=> !in_position_out)
      else $error("in-position output not opened at target");
   AST_ALARM_NC: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && alarm && ctrl[servo_io_pkg::CTRL_ALARM_NC] |=> !fault_alert_out)
      else $error("normally closed alarm output did not open");
   AST_ALARM_SWAP: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && alarm && !ctrl[servo_io_pkg::CTRL_ALARM_NC] |=> fault_alert_out && !in_position_out)
      else $error("alarm did not swap status outputs");
   AST_OC_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && sync2[servo_io_pkg::SY_OC] |=> fault[servo_io_pkg::FLT_OC] && alarm)
      else $error("over-current not latched as fault");
   AST_POWER_LED: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(rst_n) && $past(ce) |-> power_led_out)
      else $error("power indicator dark while running");
   AST_LED_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && fault == '0 |=> !fault_led_out)
      else $error("fault indicator lit without a fault");
   AST_OC_STEADY: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce && fault[servo_io_pkg::FLT_OC] ##1 ce && fault[servo_io_pkg::FLT_OC]
      |=> fault_led_out [*1])
      else $error("over-current pattern not steady");
endmodule
`default_nettype wire

// *** rtl/servo_io_pkg.sv ***
`default_nettype none
package servo_io_pkg;
   // clock and fault indicator timing
   localparam int unsigned CLK_HZ                = 25_000_000;
   localparam int unsigned LOST_STEP_INTERVAL_MS = 1000;
   localparam int unsigned OVER_VOLT_INTERVAL_MS = 2000;
   localparam int unsigned MS_PER_S              = 1000;
   // interval is one full on/off period, so each phase lasts half of it
   localparam int unsigned LOST_STEP_HALF_CYCLES =
      (CLK_HZ / MS_PER_S) * LOST_STEP_INTERVAL_MS / 2;
   localparam int unsigned OVER_VOLT_HALF_CYCLES =
      (CLK_HZ / MS_PER_S) * OVER_VOLT_INTERVAL_MS / 2;

   // register bus geometry
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BE_W   = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL       = 5'h00;
   localparam logic [ADDR_W-1:0] REG_CMD_POS    = 5'h04;
   localparam logic [ADDR_W-1:0] REG_FAULT      = 5'h08;
   localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 5'h10;
   localparam logic [ADDR_W-1:0] REG_MAX_ERR    = 5'h14;

   // control register fields
   localparam int unsigned CTRL_DOUBLE   = 0;
   localparam int unsigned CTRL_FALLING  = 1;
   localparam int unsigned CTRL_ALARM_NC = 2;
   localparam int unsigned CTRL_CLEAR    = 3;
   localparam int unsigned CTRL_W        = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET    = 3'h0;
   localparam logic [DATA_W-1:0] MAX_ERR_RESET = 32'h000007D0;

   // fault and event bit positions
   localparam int unsigned FLT_OV    = 0;
   localparam int unsigned FLT_OC    = 1;
   localparam int unsigned FLT_PE    = 2;
   localparam int unsigned FLT_W     = 3;
   localparam int unsigned EV_IN_POS = 3;
   localparam int unsigned EV_W      = 4;

   // status register extra fields
   localparam int unsigned STAT_IN_POS = 3;
   localparam int unsigned STAT_EN     = 4;
   localparam int unsigned STAT_DRV    = 5;

   // synchroniser lanes
   localparam int unsigned SY_STEP = 0;
   localparam int unsigned SY_DIR  = 1;
   localparam int unsigned SY_EN   = 2;
   localparam int unsigned SY_OV   = 3;
   localparam int unsigned SY_OC   = 4;
   localparam int unsigned SY_W    = 5;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;
endpackage
`default_nettype wire

// *** rtl/blink_timer.sv ***
`default_nettype none
module blink_timer (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        run,
   input  wire logic [31:0] half_cycles,
   output logic             lit
);
   logic [31:0] count;

   // phase counter; restarts lit whenever the pattern is (re)started
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h00000000;
         lit   <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            count <= 32'h00000000;
            lit   <= 1'b1;
         end else if (count + 32'h00000001 >= half_cycles) begin
            count <= 32'h00000000;
            lit   <= ~lit;
         end else begin
            count <= count + 32'h00000001;
         end
      end
   end
endmodule
`default_nettype wire

// *** bench/motion_ctrl_model.sv ***
`default_nettype none
module motion_ctrl_model (
   input  wire logic core_clk,
   output logic      step_in,
   output logic      dir_in,
   output logic      drive_enable_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // lines idle low with the drive off
   initial begin
      step_in         = 1'b0;
      dir_in          = 1'b0;
      drive_enable_in = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // the controller switches the drive on and off
   task automatic set_enable(input logic v);
      @(posedge core_clk);
      drive_enable_in <= v;
      hold(5);
   endtask
   // direction is settled well before the next step and then left alone
   task automatic set_dir(input logic v);
      @(posedge core_clk);
      dir_in <= v;
      hold(5);
   endtask
   // sel 0 pulses the step line, sel 1 the direction line; phases of 3 cycles beat the sync
   task automatic pulses(input bit sel, input int n);
      repeat (2 * n) begin
         @(posedge core_clk);
         if (sel) begin
            dir_in <= ~dir_in;
         end else begin
            step_in <= ~step_in;
         end
         hold(2);
      end
      hold(6);
   endtask
endmodule
`default_nettype wire

// *** bench/step_dir_servo_io_tb.sv ***
`default_nettype none
module step_dir_servo_io_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk;
   logic        arst_n;
   logic        ce;
   logic        step_in;
   logic        dir_in;
   logic        drive_enable_in;
   logic        over_voltage_in;
   logic        over_current_in;
   logic [31:0] act_pos;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        in_position_out;
   logic        fault_alert_out;
   logic        driver_on_out;
   logic        power_led_out;
   logic        fault_led_out;
   int          fails;
   int          tests_run;
   int          n;

   // short blink halves keep the run brief
   step_dir_servo_io #(.POS_W(32), .LOST_HALF_CYC(8), .VOLT_HALF_CYC(16)) step_dir_servo_io_inst (
      .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .step_in(step_in), .dir_in(dir_in),
      .drive_enable_in(drive_enable_in), .over_voltage_in(over_voltage_in),
      .over_current_in(over_current_in), .act_pos(act_pos), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .irq(irq), .in_position_out(in_position_out), .fault_alert_out(fault_alert_out),
      .driver_on_out(driver_on_out), .power_led_out(power_led_out),
      .fault_led_out(fault_led_out));
   motion_ctrl_model motion_ctrl_model_inst (
      .core_clk(core_clk), .step_in(step_in), .dir_in(dir_in),
      .drive_enable_in(drive_enable_in));

   // 25 MHz core clock
   always #20 core_clk = ~core_clk;

   task automatic tally_and_finish();
      $display("checks run %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // one avalon transfer; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int k;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 50) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      check(what, e, q);
   endtask
   task automatic pin_chk(input string what, input logic e, input logic g);
      check(what, {31'h0, e}, {31'h0, g});
   endtask
   // length of the next lit phase of the red indicator, saturating at 60
   task automatic led_run(output int len);
      int k;
      k = 0;
      len = 0;
      while (fault_led_out !== 1'b1 && k < 100) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= 100) begin
         fails++;
         tally_and_finish();
      end
      while (fault_led_out === 1'b1 && len < 60) begin
         @(posedge core_clk);
         len++;
      end
   endtask

   // main sequence: reset, step counting, outputs, faults
   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      over_voltage_in = 1'b0;
      over_current_in = 1'b0;
      act_pos = 32'h00000000;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      ce = 1'b1;
      fails = 0;
      tests_run = 0;
      repeat (8) @(posedge core_clk);
      pin_chk("power_led_out in reset", 1'b0, power_led_out);
      arst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      pin_chk("power_led_out", 1'b1, power_led_out);
      rd_chk("ctrl reset", servo_io_pkg::REG_CTRL, 32'h00000000);
      rd_chk("max_err reset", servo_io_pkg::REG_MAX_ERR, 32'h000007D0);
      // only byte lane 0 may land; the upper bytes must keep the reset limit
      avs_byteenable <= 4'h1;
      wr(servo_io_pkg::REG_MAX_ERR, 32'hFFFFFFD1);
      avs_byteenable <= 4'hF;
      rd_chk("max_err byte lane", servo_io_pkg::REG_MAX_ERR, 32'h000007D1);
      rd_chk("unmapped", 5'h18, 32'h00000000);
      motion_ctrl_model_inst.set_enable(1'b1);
      motion_ctrl_model_inst.set_dir(1'b1);
      motion_ctrl_model_inst.pulses(1'b0, 3);
      rd_chk("cmd up", servo_io_pkg::REG_CMD_POS, 32'h00000003);
      motion_ctrl_model_inst.set_dir(1'b0);
      motion_ctrl_model_inst.pulses(1'b0, 1);
      rd_chk("cmd down", servo_io_pkg::REG_CMD_POS, 32'h00000002);
      wr(servo_io_pkg::REG_CTRL, 32'h00000002);
      motion_ctrl_model_inst.pulses(1'b0, 2);
      rd_chk("cmd falling", servo_io_pkg::REG_CMD_POS, 32'h00000000);
      wr(servo_io_pkg::REG_CTRL, 32'h00000001);
      motion_ctrl_model_inst.pulses(1'b0, 5);
      rd_chk("cmd cw", servo_io_pkg::REG_CMD_POS, 32'h00000005);
      motion_ctrl_model_inst.pulses(1'b1, 2);
      rd_chk("cmd ccw", servo_io_pkg::REG_CMD_POS, 32'h00000003);
      motion_ctrl_model_inst.set_enable(1'b0);
      pin_chk("driver_on_out off", 1'b0, driver_on_out);
      motion_ctrl_model_inst.pulses(1'b0, 2);
      rd_chk("cmd disabled", servo_io_pkg::REG_CMD_POS, 32'h00000003);
      motion_ctrl_model_inst.set_enable(1'b1);
      pin_chk("driver_on_out on", 1'b1, driver_on_out);
      act_pos <= 32'h00000003;
      repeat (4) @(posedge core_clk);
      pin_chk("in_position_out reached", 1'b0, in_position_out);
      act_pos <= 32'h00000004;
      repeat (4) @(posedge core_clk);
      pin_chk("in_position_out moving", 1'b1, in_position_out);
      pin_chk("fault_alert_out open", 1'b0, fault_alert_out);
      wr(servo_io_pkg::REG_CTRL, 32'h00000004);
      repeat (3) @(posedge core_clk);
      pin_chk("fault_alert_out closed", 1'b1, fault_alert_out);
      wr(servo_io_pkg::REG_CTRL, 32'h00000000);
      wr(servo_io_pkg::REG_IRQ_MASK, 32'h00000001);
      over_voltage_in <= 1'b1;
      led_run(n);
      check("over-voltage lit phase", 32'd16, n);
      pin_chk("fault_alert_out trip", 1'b1, fault_alert_out);
      pin_chk("in_position_out trip", 1'b0, in_position_out);
      pin_chk("irq", 1'b1, irq);
      led_run(n);
      check("over-voltage second phase", 32'd16, n);
      over_current_in <= 1'b1;
      repeat (8) @(posedge core_clk);
      led_run(n);
      check("over-current steady", 32'd60, n);
      over_voltage_in <= 1'b0;
      over_current_in <= 1'b0;
      repeat (6) @(posedge core_clk);
      wr(servo_io_pkg::REG_CTRL, 32'h00000008);
      repeat (4) @(posedge core_clk);
      pin_chk("fault_led_out cleared", 1'b0, fault_led_out);
      pin_chk("fault_alert_out cleared", 1'b0, fault_alert_out);
      pin_chk("irq sticky", 1'b1, irq);
      wr(servo_io_pkg::REG_IRQ_STATUS, 32'h0000000F);
      repeat (3) @(posedge core_clk);
      pin_chk("irq cleared", 1'b0, irq);
      act_pos <= 32'd3003;
      led_run(n);
      check("lost step lit phase", 32'd8, n);
      pin_chk("fault_alert_out pos error", 1'b1, fault_alert_out);
      rd_chk("fault reg pos error", servo_io_pkg::REG_FAULT, 32'h00000014);
      rd_chk("irq status pos error", servo_io_pkg::REG_IRQ_STATUS, 32'h00000004);
      act_pos <= 32'h00000003;
      wr(servo_io_pkg::REG_CTRL, 32'h00000008);
      repeat (4) @(posedge core_clk);
      pin_chk("fault_led_out off", 1'b0, fault_led_out);
      // clock enable low must hold off the fault latch until it returns
      ce <= 1'b0;
      act_pos <= 32'd3003;
      repeat (6) @(posedge core_clk);
      pin_chk("fault_alert_out frozen", 1'b0, fault_alert_out);
      ce <= 1'b1;
      repeat (4) @(posedge core_clk);
      pin_chk("fault_alert_out after freeze", 1'b1, fault_alert_out);
      tally_and_finish();
   end
endmodule
`default_nettype wire
